// ==== rtl/fsmc_top.sv ====
// Start-up sequencing, soft-start and load-mode control of a primary-side flyback controller
`timescale 1ns/1ps
// How it works
// RULE1: Before start, enable stays low and the start-device control follows the supply.
// RULE2: Past the start threshold enable rises, temperature check, cable config, then soft-start.
// RULE3: Start at the 13.7 V start level, stop below the 5.5 V lockout level.
// RULE4: Soft-start begins with narrow gate pulses and widens them each cycle to full.
// RULE5: Every gate pulse ends as soon as the peak current comparator trips.
// RULE6: Supply below lockout at any time shuts down and drops enable.
// RULE7: The start-device control goes low in the cycle soft-start begins.
// RULE8: Each switching cycle samples the auxiliary winding into the feedback level.
// RULE9: After soft-start, normal load regulates voltage by trimming on-time and off-time.
// RULE10: No voltage on the auxiliary sense input means a broken winding: shut down.
// RULE11: Overload enters constant-current mode, fixed current, never continuous conduction.
// RULE12: Constant-current mode stops on supply lockout or output below the shutdown level.
// RULE13: Current-mode shutdown level is 3 V or 0.75 V plus cable compensation.
// RULE14: With the no-current-mode option, entering current mode shuts down instead.
// RULE15: Heavy load uses fixed frequency width modulation, then frequency modulation.
// RULE16: Frequency mode fixes on-time and lengthens off-time as load falls.
// RULE17: Near the audio band switch to deep width mode at about 25 kHz.
// RULE18: Lighter load moves to deep frequency mode with very low frequency.
// RULE19: Near no load a third width mode fixes switching near 1.8 kHz.
// RULE20: Mode boundaries carry hysteresis on the load measure to prevent toggling.
module fsmc_top #(
    parameter int NO_LOAD_PERIOD = fsmc_pkg::NO_LOAD_PERIOD_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire fsmc_pkg::fsmc_pins_t pins_i,
    input  wire logic [7:0]           aux_code_i,
    input  wire fsmc_pkg::fsmc_opt_t  opt_i,
    output logic                      gate_o,
    output logic                      enable_o,
    output logic                      start_device_ctrl_o,
    output logic                      fault_o,
    output fsmc_pkg::fsmc_mode_t      mode_o
);
    import fsmc_pkg::*;

    localparam logic [15:0] NO_LOAD_PER = 16'(NO_LOAD_PERIOD);
    logic [$bits(fsmc_pins_t)-1:0] pins_raw;
    fsmc_pins_t                    pins_s;
    fsmc_state_t                   state_ff;
    fsmc_state_t                   nxt_state;
    fsmc_mode_t                    mode_ff;
    fsmc_mode_t                    nxt_mode;
    logic [7:0]                    demand_ff;
    logic [7:0]                    nxt_demand;
    logic [15:0]                   ss_on_ff;
    logic [15:0]                   nxt_ss_on;
    logic [7:0]                    fb_ff;
    logic [7:0]                    nxt_fb;
    logic                          fault_ff;
    logic                          nxt_fault;
    logic [7:0]                    fb_new;
    logic [7:0]                    cur_sd;
    logic [15:0]                   on_w;
    logic [15:0]                   per_w;
    logic                          run_w;
    logic                          gate_w;
    logic                          cyc_w;
    logic                          smp_w;

    function automatic logic [7:0] shortfall(input logic [7:0] th, input logic [7:0] d);
        return (d < th) ? th - d : 8'h00;
    endfunction
    function automatic logic [15:0] floor_on(input logic [15:0] x);
        return (x < MIN_ON) ? MIN_ON : x;
    endfunction
    // Down at a threshold, back up only past threshold plus margin
    function automatic fsmc_mode_t step_mode(input fsmc_mode_t m, input logic [7:0] d);
        fsmc_mode_t r;
        r = m;
        unique case (m)
            MODE_WIDTH: begin
                if (d < TH_FREQ) r = MODE_FREQ;
            end
            MODE_FREQ: begin
                if (d >= TH_FREQ + HYS) r = MODE_WIDTH;
                else if (d < TH_DEEP_WIDTH) r = MODE_DEEP_WIDTH;
            end
            MODE_DEEP_WIDTH: begin
                if (d >= TH_DEEP_WIDTH + HYS) r = MODE_FREQ;
                else if (d < TH_DEEP_FREQ) r = MODE_DEEP_FREQ;
            end
            MODE_DEEP_FREQ: begin
                if (d >= TH_DEEP_FREQ + HYS) r = MODE_DEEP_WIDTH;
                else if (d < TH_NO_LOAD) r = MODE_NO_LOAD_WIDTH;
            end
            MODE_NO_LOAD_WIDTH: begin
                if (d >= TH_NO_LOAD + HYS) r = MODE_DEEP_FREQ;
            end
            MODE_CONSTANT_CURRENT: begin
                r = m;
            end
            default: begin
                r = MODE_WIDTH;
            end
        endcase
        return r;
    endfunction

    fsmc_sync #(
        .W($bits(fsmc_pins_t))
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (pins_i),
        .q_o     (pins_raw)
    );
    assign pins_s = fsmc_pins_t'(pins_raw);
    fsmc_cycle u_cycle (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .run_i       (run_w),
        .on_cycles_i (on_w),
        .period_i    (per_w),
        .ipk_trip_i  (pins_s.ipk_trip), // RULE5
        .demag_i     (pins_s.demag),
        .gate_o      (gate_w),
        .cycle_o     (cyc_w),
        .sample_o    (smp_w)
    );
    assign run_w  = (state_ff == ST_SOFT) || (state_ff == ST_RUN);
    assign fb_new = smp_w ? aux_code_i : fb_ff; // RULE8
    // Feedback is normalised, so the level applies to any output voltage
    assign cur_sd = (opt_i.cur_sd_low ? CUR_SD_LO : CUR_SD_HI)
                  + {3'b000, opt_i.cable_drop_comp}; // RULE13

    // Pulse shape per mode
    always_comb begin
        on_w  = MAX_ON;
        per_w = PWM_PERIOD;
        if (state_ff == ST_SOFT) begin
            on_w = ss_on_ff; // RULE4
        end else begin
            unique case (mode_ff)
                MODE_WIDTH: begin
                    on_w = floor_on({8'h00, demand_ff}); // RULE15
                end
                MODE_FREQ: begin
                    on_w  = ON_FREQ; // RULE16
                    per_w = PWM_PERIOD + ({8'h00, shortfall(TH_FREQ, demand_ff)} << FREQ_SH);
                end
                MODE_DEEP_WIDTH: begin
                    on_w  = floor_on({8'h00, demand_ff}); // RULE17
                    per_w = DEEP_WIDTH_PERIOD;
                end
                MODE_DEEP_FREQ: begin
                    on_w  = ON_DEEP_FREQ; // RULE18
                    per_w = DEEP_WIDTH_PERIOD
                          + ({8'h00, shortfall(TH_DEEP_FREQ, demand_ff)} << DEEP_FREQ_SH);
                end
                MODE_NO_LOAD_WIDTH: begin
                    on_w  = floor_on({8'h00, demand_ff}); // RULE19
                    per_w = NO_LOAD_PER;
                end
                MODE_CONSTANT_CURRENT: begin
                    // Peak comparator and valley wait set the current
                    on_w  = MAX_ON; // RULE11
                    per_w = PWM_PERIOD;
                end
                default: begin
                    on_w = MIN_ON;
                end
            endcase
        end
    end

    // Sequencer and regulation
    always_comb begin
        nxt_state  = state_ff;
        nxt_mode   = mode_ff;
        nxt_demand = demand_ff;
        nxt_ss_on  = ss_on_ff;
        nxt_fault  = fault_ff;
        nxt_fb     = fb_new; // RULE8
        unique case (state_ff)
            ST_OFF: begin
                nxt_fault  = 1'b0;
                nxt_ss_on  = SS_START;
                nxt_demand = 8'h00;
                nxt_mode   = MODE_WIDTH;
                if (pins_s.at_supply_start_threshold
                    && !pins_s.below_supply_lockout_threshold) begin
                    nxt_state = ST_OTP; // RULE2 RULE3
                end
            end
            ST_OTP: begin
                if (pins_s.otp_fault) begin
                    nxt_state = ST_SHUT;
                    nxt_fault = 1'b1;
                end else if (pins_s.otp_done) begin
                    nxt_state = ST_CFG; // RULE2
                end
            end
            ST_CFG: begin
                if (pins_s.cable_drop_comp_done) begin
                    nxt_state = ST_SOFT; // RULE2 RULE7
                end
            end
            ST_SOFT: begin
                if (smp_w && !pins_s.aux_present) begin
                    nxt_state = ST_SHUT; // RULE10
                    nxt_fault = 1'b1;
                end else if (cyc_w) begin
                    if (ss_on_ff >= MAX_ON) begin
                        nxt_state  = ST_RUN;
                        nxt_demand = MAX_ON[7:0];
                    end else if (ss_on_ff + SS_STEP > MAX_ON) begin
                        nxt_ss_on = MAX_ON; // RULE4
                    end else begin
                        nxt_ss_on = ss_on_ff + SS_STEP; // RULE4
                    end
                end
            end
            ST_RUN: begin
                if (smp_w) begin
                    if (!pins_s.aux_present) begin
                        nxt_state = ST_SHUT; // RULE10
                        nxt_fault = 1'b1;
                    end else if (mode_ff == MODE_CONSTANT_CURRENT) begin
                        if (fb_new < cur_sd) begin
                            nxt_state = ST_SHUT; // RULE12
                            nxt_fault = 1'b1;
                        end else if (fb_new >= FB_TARGET) begin
                            nxt_mode = MODE_WIDTH; // RULE11
                        end
                    end else if (demand_ff == DEMAND_MAX
                                 && fb_new < FB_TARGET - CUR_MARGIN) begin
                        if (opt_i.no_current_mode) begin
                            nxt_state = ST_SHUT; // RULE14
                            nxt_fault = 1'b1;
                        end else begin
                            nxt_mode = MODE_CONSTANT_CURRENT; // RULE11
                        end
                    end else begin
                        // Demand is the load measure; one step per sampled cycle
                        if (fb_new < FB_TARGET && demand_ff != DEMAND_MAX) begin
                            nxt_demand = demand_ff + 8'h01; // RULE9
                        end else if (fb_new > FB_TARGET && demand_ff != 8'h00) begin
                            nxt_demand = demand_ff - 8'h01; // RULE9
                        end
                        nxt_mode = step_mode(mode_ff, demand_ff); // RULE20
                    end
                end
            end
            ST_SHUT: begin
                // Stays biased so the supply drains down to lockout
                nxt_state = ST_SHUT;
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
        if (pins_s.below_supply_lockout_threshold) begin
            nxt_state = ST_OFF; // RULE6 RULE3 RULE12
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff  <= ST_OFF;
            mode_ff   <= MODE_WIDTH;
            demand_ff <= 8'h00;
            ss_on_ff  <= SS_START;
            fb_ff     <= 8'h00;
            fault_ff  <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            mode_ff   <= nxt_mode;
            demand_ff <= nxt_demand;
            ss_on_ff  <= nxt_ss_on;
            fb_ff     <= nxt_fb;
            fault_ff  <= nxt_fault;
        end
    end

    assign gate_o              = gate_w && run_w;
    assign enable_o            = (state_ff != ST_OFF); // RULE2 RULE6
    assign start_device_ctrl_o = (state_ff == ST_OFF) || (state_ff == ST_OTP)
                               || (state_ff == ST_CFG); // RULE1 RULE7
    assign fault_o             = fault_ff;
    assign mode_o              = mode_ff;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_start_track: assert property ( // RULE1
        state_ff == ST_OFF |-> start_device_ctrl_o && !enable_o && !gate_o)
        else $error("start device not released before start");
    chk_enable_launch: assert property ( // RULE2
        state_ff == ST_OFF && pins_s.at_supply_start_threshold
        && !pins_s.below_supply_lockout_threshold |=> enable_o && state_ff == ST_OTP)
        else $error("enable not raised at start threshold");
    chk_soft_order: assert property ( // RULE2
        $rose(state_ff == ST_SOFT) |-> $past(state_ff) == ST_CFG
        && $past(pins_s.cable_drop_comp_done))
        else $error("soft-start began out of order");
    chk_ctrl_drop: assert property ( // RULE7
        $rose(state_ff == ST_SOFT) |-> !start_device_ctrl_o && enable_o)
        else $error("start device not cut when soft-start began");
    chk_soft_widen: assert property ( // RULE4
        state_ff == ST_SOFT && cyc_w && ss_on_ff < MAX_ON && nxt_state == ST_SOFT
        |=> ss_on_ff > $past(ss_on_ff) && ss_on_ff <= MAX_ON)
        else $error("soft-start pulse did not widen");
    chk_peak_cut: assert property ( // RULE5
        gate_o && pins_s.ipk_trip |=> !gate_o [*2])
        else $error("gate not ended by peak trip");
    chk_lockout_off: assert property ( // RULE6
        pins_s.below_supply_lockout_threshold && state_ff != ST_OFF
        |=> !enable_o && !gate_o && start_device_ctrl_o)
        else $error("no shutdown on supply lockout");
    chk_aux_missing: assert property ( // RULE10
        state_ff == ST_RUN && smp_w && !pins_s.aux_present
        && !pins_s.below_supply_lockout_threshold |=> state_ff == ST_SHUT && fault_o)
        else $error("missing auxiliary voltage not caught");
    chk_cur_shutdown: assert property ( // RULE12
        state_ff == ST_RUN && mode_ff == MODE_CONSTANT_CURRENT && smp_w
        && pins_s.aux_present && aux_code_i < cur_sd
        && !pins_s.below_supply_lockout_threshold |=> state_ff == ST_SHUT)
        else $error("current mode output collapse not caught");
    chk_no_cur_trip: assert property ( // RULE14
        state_ff == ST_RUN && opt_i.no_current_mode && smp_w && pins_s.aux_present
        && mode_ff != MODE_CONSTANT_CURRENT && demand_ff == DEMAND_MAX
        && aux_code_i < FB_TARGET - CUR_MARGIN
        && !pins_s.below_supply_lockout_threshold |=> state_ff == ST_SHUT)
        else $error("overload not shut down without current mode");
    chk_fb_capture: assert property ( // RULE8
        smp_w |=> fb_ff == $past(aux_code_i))
        else $error("feedback level not captured at sample");
    chk_mode_step: assert property ( // RULE20
        state_ff == ST_RUN && mode_ff == MODE_WIDTH && !smp_w |=> mode_ff == MODE_WIDTH)
        else $error("mode changed without a sample");
    cov_run: cover property ($rose(state_ff == ST_RUN));
    cov_current: cover property ($rose(mode_ff == MODE_CONSTANT_CURRENT));
    cov_no_load: cover property ($rose(mode_ff == MODE_NO_LOAD_WIDTH));
    cov_shut: cover property ($rose(state_ff == ST_SHUT));
endmodule

// ==== rtl/fsmc_pkg.sv ====
// Shared constants, states, modes and pin bundles of the flyback start-up and mode control
package fsmc_pkg;

    localparam int CLK_HZ     = 40_000_000;
    localparam int FSW_MAX_HZ = 89_000;
    localparam int DEEP_HZ    = 25_000;
    localparam int NO_LOAD_HZ = 1_800;

    // Least period rounds up so the top frequency is never exceeded
    localparam logic [15:0] PWM_PERIOD        = 16'((CLK_HZ + FSW_MAX_HZ - 1) / FSW_MAX_HZ);
    localparam logic [15:0] DEEP_WIDTH_PERIOD = 16'(CLK_HZ / DEEP_HZ);
    localparam int          NO_LOAD_PERIOD_CYC = CLK_HZ / NO_LOAD_HZ;

    // Supply levels resolved by the external comparators feeding the pin bundle
    localparam int SUPPLY_START_MV   = 13_700;
    localparam int SUPPLY_LOCKOUT_MV = 5_500;

    // Feedback code is normalised to a 5 V nominal output, so other outputs scale for free
    localparam int FB_LSB_MV = 25;
    localparam int FB_NOM_MV = 5_000;
    localparam logic [7:0] FB_TARGET  = 8'(FB_NOM_MV / FB_LSB_MV);
    localparam logic [7:0] CUR_SD_HI  = 8'(3_000 / FB_LSB_MV);
    localparam logic [7:0] CUR_SD_LO  = 8'(750 / FB_LSB_MV);
    localparam logic [7:0] CUR_MARGIN = 8'h10;

    localparam logic [15:0] MAX_ON       = 16'h00ff;
    localparam logic [15:0] MIN_ON       = 16'h0004;
    localparam logic [15:0] SS_START     = 16'h0008;
    localparam logic [15:0] SS_STEP      = 16'h0008;
    localparam logic [15:0] ON_FREQ      = 16'h0060;
    localparam logic [15:0] ON_DEEP_FREQ = 16'h0030;
    localparam logic [15:0] SAMPLE_DLY   = 16'h0010;

    localparam logic [7:0] DEMAND_MAX    = 8'hff;
    localparam logic [7:0] TH_FREQ       = 8'h80;
    localparam logic [7:0] TH_DEEP_WIDTH = 8'h40;
    localparam logic [7:0] TH_DEEP_FREQ  = 8'h20;
    localparam logic [7:0] TH_NO_LOAD    = 8'h08;
    localparam logic [7:0] HYS           = 8'h06;
    localparam int         FREQ_SH       = 4;
    localparam int         DEEP_FREQ_SH  = 9;

    typedef enum logic [5:0] {
        ST_OFF  = 6'h01,
        ST_OTP  = 6'h02,
        ST_CFG  = 6'h04,
        ST_SOFT = 6'h08,
        ST_RUN  = 6'h10,
        ST_SHUT = 6'h20
    } fsmc_state_t;

    typedef enum logic [5:0] {
        MODE_WIDTH            = 6'h01,
        MODE_FREQ             = 6'h02,
        MODE_DEEP_WIDTH       = 6'h04,
        MODE_DEEP_FREQ        = 6'h08,
        MODE_NO_LOAD_WIDTH    = 6'h10,
        MODE_CONSTANT_CURRENT = 6'h20
    } fsmc_mode_t;

    typedef struct packed {
        logic at_supply_start_threshold;
        logic below_supply_lockout_threshold;
        logic otp_done;
        logic otp_fault;
        logic cable_drop_comp_done;
        logic ipk_trip;
        logic aux_present;
        logic demag;
    } fsmc_pins_t;

    typedef struct packed {
        logic       no_current_mode;
        logic       cur_sd_low;
        logic [4:0] cable_drop_comp;
    } fsmc_opt_t;

endpackage

// ==== rtl/fsmc_sync.sv ====
// Two-flop synchroniser for the comparator and sequencing pins
`timescale 1ns/1ps
module fsmc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

// ==== rtl/fsmc_cycle.sv ====
// Switching cycle timer: gate pulse, peak cut-off, valley wait and feedback sample strobe
`timescale 1ns/1ps
module fsmc_cycle (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        run_i,
    input  wire logic [15:0] on_cycles_i,
    input  wire logic [15:0] period_i,
    input  wire logic        ipk_trip_i,
    input  wire logic        demag_i,
    output logic             gate_o,
    output logic             cycle_o,
    output logic             sample_o
);
    import fsmc_pkg::*;

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] off_at_ff;
    logic [15:0] nxt_off_at;
    logic        gate_ff;
    logic        nxt_gate;
    logic        dm_ff;
    logic        nxt_dm;
    logic        dmp_ff;
    logic        nxt_dmp;
    logic [15:0] on_ff;
    logic [15:0] nxt_on;
    logic        cyc_ff;
    logic        nxt_cyc;
    logic        smp_ff;
    logic        nxt_smp;
    logic        restart;

    always_comb begin
        nxt_cnt    = (cnt_ff == 16'hffff) ? cnt_ff : cnt_ff + 16'h0001;
        nxt_gate   = gate_ff;
        nxt_off_at = off_at_ff;
        nxt_on     = on_ff;
        nxt_dmp    = demag_i;
        nxt_cyc    = 1'b0;
        nxt_smp    = 1'b0;
        // No new pulse before the winding has let go: keeps conduction discontinuous
        restart    = run_i && !gate_ff && dm_ff && (cnt_ff >= period_i - 16'h0001); // RULE11
        // A knee rising as the flag is consumed still counts; a standing level does not
        nxt_dm     = (dm_ff && !restart) || (demag_i && !dmp_ff && !gate_ff);
        if (!run_i) begin
            nxt_cnt  = 16'hffff;
            nxt_gate = 1'b0;
            nxt_dm   = 1'b1;
        end else if (gate_ff) begin
            if (ipk_trip_i || nxt_cnt >= on_ff) begin // RULE5
                nxt_gate   = 1'b0;
                nxt_off_at = cnt_ff;
            end
        end else if (restart) begin
            nxt_cnt  = 16'h0000;
            nxt_gate = 1'b1;
            nxt_cyc  = 1'b1;
            // Held for the whole pulse, so a soft-start step lands on the next one
            nxt_on   = on_cycles_i;
        end else if (cnt_ff == off_at_ff + SAMPLE_DLY) begin
            nxt_smp = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff    <= 16'hffff;
            off_at_ff <= 16'h0000;
            gate_ff   <= 1'b0;
            dm_ff     <= 1'b1;
            dmp_ff    <= 1'b1;
            on_ff     <= 16'h0000;
            cyc_ff    <= 1'b0;
            smp_ff    <= 1'b0;
        end else begin
            cnt_ff    <= nxt_cnt;
            off_at_ff <= nxt_off_at;
            gate_ff   <= nxt_gate;
            dm_ff     <= nxt_dm;
            dmp_ff    <= nxt_dmp;
            on_ff     <= nxt_on;
            cyc_ff    <= nxt_cyc;
            smp_ff    <= nxt_smp;
        end
    end

    assign gate_o   = gate_ff;
    assign cycle_o  = cyc_ff;
    assign sample_o = smp_ff;
endmodule

// ==== test/fsmc_far.sv ====
// Far-side model: switch current ramp, auxiliary winding and knee detection
`timescale 1ns/1ps
module fsmc_far (
    input  wire logic       clk_i,
    input  wire logic       gate_i,
    input  wire logic [7:0] trip_after_i,
    input  wire logic       aux_ok_i,
    input  wire logic [7:0] code_i,
    output logic            ipk_trip_o,
    output logic            demag_o,
    output logic            aux_present_o,
    output logic [7:0]      aux_code_o
);
    logic [7:0] on_cnt = 8'h00;
    logic [7:0] off_cnt = 8'h00;
    always @(posedge clk_i) begin
        on_cnt <= gate_i ? on_cnt + 8'h01 : 8'h00;
        off_cnt <= (gate_i || off_cnt == 8'hff) ? {8{~gate_i}} & off_cnt : off_cnt + 8'h01;
    end
    // Zero trip count means the current never reaches the limit
    assign ipk_trip_o = gate_i && trip_after_i != 8'h00 && on_cnt >= trip_after_i;
    // Knee shows some time after turn-off, so a restart must wait for it
    assign demag_o = !gate_i && off_cnt >= 8'h20;
    assign aux_present_o = aux_ok_i && !gate_i;
    // A dead winding gives no plateau, so the code wanders every cycle
    assign aux_code_o = aux_ok_i ? code_i : off_cnt;
endmodule

// ==== test/tb.sv ====
// Self-checking bench for start-up, soft-start, peak cut-off, width and constant-current modes
`timescale 1ns/1ps
module tb;
    import fsmc_pkg::*;
    logic clk_i = 0, rst_n_i = 0, st = 0, lo = 0, od = 0, cd = 0, ok = 1;
    logic [7:0] trip = 8'h00, code = 8'hc8, acode;
    logic gate_o, enable_o, sdc_o, fault_o, itrip, dm, ap;
    logic [31:0] rs = 32'h0000_1ed3;
    fsmc_opt_t opt = '0;
    fsmc_pins_t pins;
    fsmc_mode_t mode_o;
    int n_mismatch = 0, n_compared = 0, cyc = 0, w, k, j;
    assign pins = '{st, lo, od, 1'b0, cd, itrip, ap, dm};
    fsmc_top #(.NO_LOAD_PERIOD(2000)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins),
        .aux_code_i(acode), .opt_i(opt), .gate_o(gate_o), .enable_o(enable_o),
        .start_device_ctrl_o(sdc_o), .fault_o(fault_o), .mode_o(mode_o));
    fsmc_far i_far (.clk_i(clk_i), .gate_i(gate_o), .trip_after_i(trip), .aux_ok_i(ok),
        .code_i(code), .ipk_trip_o(itrip), .demag_o(dm), .aux_present_o(ap), .aux_code_o(acode));
    initial forever #12.5 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Bounded waits: a missing pulse ends the wait rather than hanging
    task automatic pulse;
        for (k = 0; gate_o !== 1'b1 && k < 3000; k++) @(negedge clk_i);
        for (w = 0; gate_o === 1'b1 && w < 300; w++) @(negedge clk_i);
    endtask
    task automatic power_up;
        st = 1;
        repeat (5) @(negedge clk_i);
        chk("enable", 1, enable_o);
        chk("start_dev_on", 1, sdc_o);
        od = 1;
        repeat (5) @(negedge clk_i);
        chk("gate_before_cfg", 0, gate_o);
        chk("start_dev_cfg", 1, sdc_o);
        cd = 1;
        for (k = 0; sdc_o !== 1'b0 && k < 8; k++) @(negedge clk_i);
        chk("start_dev_off", 0, sdc_o);
        chk("gate_at_soft", 0, gate_o);
    endtask
    task automatic to_full;
        for (j = 0; j < 40 && w != 255; j++) pulse;
        chk("soft_full", MAX_ON, 16'(w));
    endtask
    task automatic lockout;
        {st, od, cd, lo} = 4'b0001;
        repeat (4) @(negedge clk_i);
        chk("enable_lock", 0, enable_o);
        chk("fault_lock", 0, fault_o);
        chk("start_dev_lock", 1, sdc_o);
        chk("gate_lock", 0, gate_o);
        lo = 0;
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        chk("enable_rst", 0, enable_o);
        chk("start_dev_rst", 1, sdc_o);
        rst_n_i = 1;
        opt.cable_drop_comp = 5'h04;
        power_up;
        for (j = 1; j <= 3; j++) begin
            pulse;
            chk("soft_width", 16'(SS_START + SS_STEP * 16'(j - 1)), 16'(w));
        end
        trip = 8'h05;
        pulse;
        chk("trip_cut", 1, 16'(w >= 5 && w < 16));
        trip = 8'h00;
        to_full;
        for (j = 0; j < 20; j++) begin
            rs = lfsr(rs);
            code = 8'hbe + 8'(rs % 11);
            pulse;
            chk("run_fault", 0, fault_o);
            chk("run_mode", MODE_WIDTH, mode_o);
        end
        code = 8'h96;
        repeat (3) pulse;
        chk("cc_mode", MODE_CONSTANT_CURRENT, mode_o);
        code = CUR_SD_HI + 8'h04;
        repeat (2) pulse;
        chk("cc_at_level", 0, fault_o);
        code = code - 8'h01;
        repeat (2) pulse;
        chk("cc_below_level", 1, fault_o);
        lockout;
        ok = 0;
        power_up;
        repeat (2) pulse;
        chk("aux_fault", 1, fault_o);
        ok = 1;
        lockout;
        opt.no_current_mode = 1;
        code = 8'hc8;
        power_up;
        to_full;
        code = 8'h96;
        repeat (3) pulse;
        chk("no_cc_fault", 1, fault_o);
        conclude;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            conclude;
        end
    end
endmodule
